// ---- logic/bts_branch_unit.sv ----
// Branch decode and next fetch address selection
`timescale 1ns/1ns
`include "bts_cfg.svh"
module bts_branch_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Instruction issue from fetch
    input wire logic issue_valid,
    input wire bts_pkg::bts_word_t issue_insn,
    input wire bts_pkg::bts_word_t issue_addr,
    // Core register state
    input wire bts_pkg::bts_word_t condition_bits_reg,
    input wire bts_pkg::bts_word_t return_address_reg,
    input wire bts_pkg::bts_word_t loop_count_reg,
    // Fetch redirect
    output logic redirect_valid,
    output bts_pkg::bts_word_t redirect_addr,
    output logic branch_done,
    output logic invalid_form,
    // Register updates
    output logic return_address_we,
    output bts_pkg::bts_word_t return_address_wdata,
    output logic loop_count_we,
    output bts_pkg::bts_word_t loop_count_wdata
);
    import bts_pkg::*;

    // Timing: an instruction presented with issue_valid is decoded in the same
    // cycle, and every result appears one clock later as a one-cycle pulse.
    // Back-to-back issue is allowed, but nothing is forwarded from the update
    // ports to the register inputs: the caller applies a write before it issues
    // the next branch that reads the same register.
    // Words that are not one of the branch forms produce no pulse at all, so
    // the block can share an issue bus with other execution units.
    // Every output comes from a flip-flop, which costs a cycle of latency but
    // keeps the long adder and mux paths out of the fetch unit's timing.
    // The target mux always runs; only the pulses say whether it is used.
    // Reset clears every pulse and data register in one synchronous cycle.

    // Read one option bit by its big-endian position
    function automatic logic opt_bit(input logic [4:0] opts, input int idx);
        opt_bit = opts[4 - idx];
    endfunction

    // Primary opcode of an instruction word
    function automatic logic [5:0] primary_op(input bts_word_t insn);
        primary_op = insn[`BTS_OPC_MSB:`BTS_OPC_LSB];
    endfunction

    // Extended opcode of the register-target forms, read twice in the decode
    function automatic logic [9:0] ext_op(input bts_word_t insn);
        ext_op = insn[`BTS_XO_MSB:`BTS_XO_LSB];
    endfunction

    // Immediate target: used as is when absolute, else added to the branch address
    function automatic bts_word_t pick_target(input bts_word_t imm, input logic abs_sel,
        input bts_word_t here);
        pick_target = abs_sel ? imm : imm + here;
    endfunction

    // Decode intermediates
    bts_form_t form;
    logic [4:0] branch_options_field;
    logic [4:0] condition_index;
    logic link_update_flag;
    logic absolute_flag;
    logic cond_bit;
    logic cond_ok;
    logic ctr_ok;
    logic taken;
    logic bad;
    bts_word_t ctr_dec;
    bts_word_t imm_ext;
    bts_word_t target;
    // Qualified requests and named option bits
    logic is_branch;
    logic link_req;
    logic ctr_req;
    logic ctr_zero;
    logic opt_nocond;
    logic opt_true;
    logic opt_noctr;
    logic opt_ctrz;
    logic [31:0] cond_mirror;
    bts_word_t seq_addr;

    // Field extraction
    // Fields are numbered from bit 0 at the least significant end here
    assign branch_options_field = issue_insn[`BTS_BO_MSB:`BTS_BO_LSB];
    assign condition_index = issue_insn[`BTS_BI_MSB:`BTS_BI_LSB];
    assign link_update_flag = issue_insn[`BTS_LK_BIT]; // [RL13]
    assign absolute_flag = issue_insn[`BTS_AA_BIT];
    assign ctr_dec = loop_count_reg - `BTS_CTR_DEC;
    // Zero test on the decremented count, as the loop idiom expects
    assign ctr_zero = (ctr_dec == 32'h0000_0000);

    // Option bits by name; bit 0 of the options field is its most significant
    assign opt_nocond = opt_bit(branch_options_field, `BTS_BO_NOCOND);
    assign opt_true = opt_bit(branch_options_field, `BTS_BO_TRUE);
    assign opt_noctr = opt_bit(branch_options_field, `BTS_BO_NOCTR);
    assign opt_ctrz = opt_bit(branch_options_field, `BTS_BO_CTRZ);

    // Mirror the condition word so that the index field addresses it directly
    for (genvar i = 0; i < 32; i++) begin : g_cond_mirror
        assign cond_mirror[i] = condition_bits_reg[31 - i];
    end

    // Qualified decode results shared by the output registers
    assign is_branch = issue_valid && (form != BTS_FORM_NONE);
    // Link follows the flag alone, taken or not; the invalid form writes nothing
    assign link_req = is_branch && link_update_flag && !bad; // [RL12] [RL13]
    // Only the immediate and return-register conditional forms may decrement
    assign ctr_req = issue_valid && ((form == BTS_FORM_COND) || (form == BTS_FORM_RET))
        && !opt_noctr; // [RL14]
    // Address of the instruction that follows the branch
    assign seq_addr = issue_addr + `BTS_INSN_STEP;

    // Classify the instruction form
    // Unknown extended codes under the register-form opcode leave no form
    always_comb begin
        form = BTS_FORM_NONE;
        case (primary_op(issue_insn))
            `BTS_OPC_B: form = BTS_FORM_IMM;
            `BTS_OPC_BC: form = BTS_FORM_COND;
            `BTS_OPC_XL: begin
                if (ext_op(issue_insn) == `BTS_XO_BCLR) begin
                    form = BTS_FORM_RET;
                end else if (ext_op(issue_insn) == `BTS_XO_BCCTR) begin
                    form = BTS_FORM_CNT;
                end
            end
            default: form = BTS_FORM_NONE;
        endcase
    end

    // Condition and count tests; register branches share the same decode.
    // The count test looks at the decremented value, as the loop idiom wants.
    always_comb begin
        // Bit 0 of the condition register is its most significant bit
        cond_bit = cond_mirror[condition_index]; // [RL4]
        cond_ok = opt_nocond || (cond_bit == opt_true); // [RL4] [RL14]
        ctr_ok = opt_noctr || (ctr_zero == opt_ctrz); // [RL14]
        // Decrement on the count-register form would clobber its own target
        bad = (form == BTS_FORM_CNT) && !opt_noctr; // [RL8]
    end

    // Target and taken selection
    // Register targets drop the two low bits; immediate targets already end in 00
    always_comb begin
        imm_ext = 32'h0000_0000;
        target = 32'h0000_0000;
        taken = 1'b0;
        case (form)
            BTS_FORM_IMM: begin
                imm_ext = {{6{issue_insn[`BTS_LI_MSB]}},
                    issue_insn[`BTS_LI_MSB:`BTS_LI_LSB], 2'b00};
                target = pick_target(imm_ext, absolute_flag, issue_addr); // [RL1] [RL2]
                taken = 1'b1;
            end
            BTS_FORM_COND: begin
                imm_ext = {{16{issue_insn[`BTS_BD_MSB]}},
                    issue_insn[`BTS_BD_MSB:`BTS_BD_LSB], 2'b00};
                target = pick_target(imm_ext, absolute_flag, issue_addr); // [RL1] [RL2]
                taken = cond_ok && ctr_ok; // [RL5]
            end
            BTS_FORM_RET: begin
                target = {return_address_reg[31:2], 2'b00}; // [RL6] [RL15]
                taken = cond_ok && ctr_ok; // [RL6]
            end
            BTS_FORM_CNT: begin
                target = {loop_count_reg[31:2], 2'b00}; // [RL7] [RL15]
                taken = cond_ok && !bad; // [RL7] [RL8]
            end
            default: begin
                target = 32'h0000_0000;
                taken = 1'b0;
            end
        endcase
    end

    // Fetch redirect and completion, one cycle after issue
    // A not-taken branch still completes, so fetch can retire it in order
    always_ff @(posedge core_clk) begin
        if (reset) begin
            redirect_valid <= 1'b0;
            redirect_addr <= 32'h0000_0000;
            branch_done <= 1'b0;
            invalid_form <= 1'b0;
        end else begin
            redirect_valid <= is_branch && taken; // [RL5] [RL6] [RL7]
            // Not-taken branches report the sequential address
            redirect_addr <= taken ? target : seq_addr; // [RL5]
            branch_done <= is_branch && !bad;
            invalid_form <= issue_valid && bad; // [RL8]
        end
    end

    // Link write uses the old register value for the target, so it lands after
    // Registered with the redirect so that both land on the same edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            return_address_we <= 1'b0;
            return_address_wdata <= 32'h0000_0000;
        end else begin
            return_address_we <= link_req; // [RL3] [RL12]
            return_address_wdata <= seq_addr; // [RL3]
        end
    end

    // Count decrement for conditional forms that request it
    // The count-register form never decrements: that option makes it invalid
    always_ff @(posedge core_clk) begin
        if (reset) begin
            loop_count_we <= 1'b0;
            loop_count_wdata <= 32'h0000_0000;
        end else begin
            loop_count_we <= ctr_req; // [RL14]
            loop_count_wdata <= ctr_dec;
        end
    end
endmodule // bts_branch_unit

// ---- logic/bts_cfg.svh ----
// Constants for the branch target select block
// Behaviour
// [RL1] Relative target is displacement plus branch address
// [RL2] Absolute target is the immediate field itself
// [RL3] Linking branch writes next instruction address
// [RL4] Condition index picks one condition bit
// [RL5] Conditional absolute redirects only when condition met
// [RL6] Return-register branch takes target from return register
// [RL7] Count-register branch takes target from count register
// [RL8] Count branch with decrement option is invalid
// [RL9] Software keeps loop counts in count register
// [RL10] Computed jumps use count branch without link
// [RL11] Calls link; returns use return branch without link
// [RL12] Link written whether or not branch taken
// [RL13] Link flag is least significant instruction bit
// [RL14] Options decode decrement, zero test, condition test
// [RL15] Register targets clear two low-order bits
`ifndef BTS_CFG_SVH
`define BTS_CFG_SVH
// Primary opcode field, instruction bits 0..5 (bit 0 = MSB)
`define BTS_OPC_MSB 31
`define BTS_OPC_LSB 26
`define BTS_OPC_B 6'h12
`define BTS_OPC_BC 6'h10
`define BTS_OPC_XL 6'h13
// Extended opcode of register forms, bits 21..30
`define BTS_XO_MSB 10
`define BTS_XO_LSB 1
`define BTS_XO_BCLR 10'h010
`define BTS_XO_BCCTR 10'h210
// Field positions (little-endian numbering of the 32-bit word)
`define BTS_BO_MSB 25
`define BTS_BO_LSB 21
`define BTS_BI_MSB 20
`define BTS_BI_LSB 16
`define BTS_LI_MSB 25
`define BTS_LI_LSB 2
`define BTS_BD_MSB 15
`define BTS_BD_LSB 2
`define BTS_AA_BIT 1
`define BTS_LK_BIT 0
// Branch options bits, numbered 0..4 from the most significant
`define BTS_BO_NOCTR 2
`define BTS_BO_CTRZ 3
`define BTS_BO_NOCOND 0
`define BTS_BO_TRUE 1
`define BTS_INSN_STEP 32'h0000_0004
// Loop count step per decrement
`define BTS_CTR_DEC 32'h0000_0001
`endif

// ---- logic/bts_pkg.sv ----
// Types for the branch target select block
package bts_pkg;
    typedef enum logic [2:0] {
        BTS_FORM_NONE,
        BTS_FORM_IMM,
        BTS_FORM_COND,
        BTS_FORM_RET,
        BTS_FORM_CNT
    } bts_form_t;
    typedef logic [31:0] bts_word_t;
endpackage

// ---- tb/bts_core_regs.sv ----
// Far-side model of the return-address and loop-count registers
`timescale 1ns/1ns
module bts_core_regs #(
    parameter bts_pkg::bts_word_t RA_INIT = 32'h2003,
    parameter bts_pkg::bts_word_t CNT_INIT = 32'h1237
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Writes from the branch unit, then current values
    input wire logic return_address_we,
    input wire bts_pkg::bts_word_t return_address_wdata,
    input wire logic loop_count_we,
    input wire bts_pkg::bts_word_t loop_count_wdata,
    output bts_pkg::bts_word_t return_address_reg,
    output bts_pkg::bts_word_t loop_count_reg
);
    import bts_pkg::*;
    // A write shows one cycle after its pulse, so readers leave an idle cycle
    always_ff @(posedge core_clk) begin
        if (reset) return_address_reg <= RA_INIT;
        else if (return_address_we) return_address_reg <= return_address_wdata;
    end
    // Low bits left set on purpose so target masking is exercised
    always_ff @(posedge core_clk) begin
        if (reset) loop_count_reg <= CNT_INIT;
        else if (loop_count_we) loop_count_reg <= loop_count_wdata;
    end
endmodule // bts_core_regs

// ---- tb/bts_branch_props.sv ----
// Port checks for the branch unit
`timescale 1ns/1ns
module bts_branch_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Watched ports
    input wire logic issue_valid,
    input wire bts_pkg::bts_word_t issue_insn,
    input wire bts_pkg::bts_word_t issue_addr,
    input wire bts_pkg::bts_word_t condition_bits_reg,
    input wire bts_pkg::bts_word_t return_address_reg,
    input wire bts_pkg::bts_word_t loop_count_reg,
    input wire logic redirect_valid,
    input wire bts_pkg::bts_word_t redirect_addr,
    input wire logic invalid_form,
    input wire logic return_address_we,
    input wire bts_pkg::bts_word_t return_address_wdata
);
    import bts_pkg::*;
    logic ib, cb, rb, kb, go, ct;
    bts_word_t li, rt;
    // Decode helpers; go means neither count nor condition is tested
    assign ib = issue_valid && issue_insn[31:26] == 6'h12;
    assign cb = issue_valid && issue_insn[31:26] == 6'h10;
    assign rb = issue_valid && issue_insn[31:26] == 6'h13 && issue_insn[10:1] == 10'h010;
    assign kb = issue_valid && issue_insn[31:26] == 6'h13 && issue_insn[10:1] == 10'h210;
    assign go = issue_insn[25] && issue_insn[23];
    assign li = {{6{issue_insn[25]}}, issue_insn[25:2], 2'h0};
    // Relative target and selected condition outcome, sampled through $past
    assign rt = issue_addr + li;
    assign ct = condition_bits_reg[5'h1F - issue_insn[20:16]] == issue_insn[24];
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_rel_target: assert property (ib && !issue_insn[1] |=>
        redirect_valid && redirect_addr == $past(rt)) else $error("rel target");
    a_abs_target: assert property (ib && issue_insn[1] |=>
        redirect_valid && redirect_addr == $past(li)) else $error("abs target");
    a_link_data: assert property (return_address_we |->
        return_address_wdata == $past(issue_addr) + 32'h4) else $error("link value");
    a_link_flag: assert property (ib || cb |=>
        return_address_we == $past(issue_insn[0])) else $error("link flag");
    a_cond_test: assert property (cb && !issue_insn[25] && issue_insn[23] |=>
        redirect_valid == $past(ct)) else $error("condition");
    a_ret_target: assert property (rb && go |=> redirect_valid &&
        redirect_addr == ($past(return_address_reg) & 32'hFFFFFFFC)) else $error("ret target");
    a_cnt_target: assert property (kb && go |=> redirect_valid &&
        redirect_addr == ($past(loop_count_reg) & 32'hFFFFFFFC)) else $error("cnt target");
    a_bad_form: assert property (kb && !issue_insn[23] |=> invalid_form &&
        !redirect_valid && !return_address_we) else $error("bad form");
endmodule // bts_branch_props
bind bts_branch_unit bts_branch_props u_props (.core_clk, .reset, .issue_valid, .issue_insn,
    .issue_addr, .condition_bits_reg, .return_address_reg, .loop_count_reg, .redirect_valid,
    .redirect_addr, .invalid_form, .return_address_we, .return_address_wdata);

// ---- tb/tb_branch_target_select.sv ----
// Scenario bench for the branch unit
`timescale 1ns/1ns
module tb_branch_target_select;
    import bts_pkg::*;
    logic core_clk = 1'h0, reset = 1'h1, issue_valid = 1'h0;
    logic redirect_valid, branch_done, invalid_form, return_address_we, loop_count_we;
    bts_word_t issue_insn = 32'h0, issue_addr = 32'h0, condition_bits_reg = 32'h0;
    bts_word_t redirect_addr, return_address_wdata, loop_count_wdata;
    bts_word_t return_address_reg, loop_count_reg;
    int fails = 0, checks_done = 0;
    always #2 core_clk = ~core_clk;
    bts_branch_unit DUT (.core_clk, .reset, .issue_valid, .issue_insn, .issue_addr,
        .condition_bits_reg, .return_address_reg, .loop_count_reg, .redirect_valid,
        .redirect_addr, .branch_done, .invalid_form, .return_address_we,
        .return_address_wdata, .loop_count_we, .loop_count_wdata);
    bts_core_regs u_regs (.core_clk, .reset, .return_address_we, .return_address_wdata,
        .loop_count_we, .loop_count_wdata, .return_address_reg, .loop_count_reg);
    // Compare a settled output with its expected value
    task automatic cmp(input bts_word_t got, exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One issue after an idle cycle; fl is {redirect, done, link, count, invalid}
    task automatic issue(input bts_word_t insn, a, input logic [4:0] fl, input bts_word_t t);
        @(posedge core_clk);
        #1 issue_valid = 1'h1;
        issue_insn = insn;
        issue_addr = a;
        @(posedge core_clk);
        #1 issue_valid = 1'h0;
        cmp({27'h0, redirect_valid, branch_done, return_address_we, loop_count_we,
            invalid_form}, {27'h0, fl});
        if (fl[4]) cmp(redirect_addr, t);
        if (fl[3] && !fl[4]) cmp(redirect_addr, a + 32'h4);
        if (fl[2]) cmp(return_address_wdata, a + 32'h4);
    endtask
    task automatic t_regs;
        issue(32'h4E800420, 32'h5000, 5'h18, 32'h1234);
        issue(32'h4E800020, 32'h6000, 5'h18, 32'h2000);
        issue(32'h4E000421, 32'h5000, 5'h01, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_link;
        issue(32'h48000011, 32'h1000, 5'h1C, 32'h1010);
        issue(32'h4E800020, 32'h1010, 5'h18, 32'h1004);
        issue(32'h4BFFFF03, 32'h2000, 5'h1C, 32'hFFFFFF00);
        $display("test link done");
    endtask
    task automatic t_cond;
        condition_bits_reg = 32'h04000000;
        issue(32'h41850043, 32'h3000, 5'h1C, 32'h40);
        condition_bits_reg = 32'hFBFFFFFF;
        issue(32'h41850043, 32'h3000, 5'h0C, 32'h0);
        $display("test cond done");
    endtask
    // Count still holds its start value here, since the invalid form wrote nothing
    task automatic t_loop;
        issue(32'h4200FFF0, 32'h4000, 5'h1A, 32'h3FF0);
        cmp(loop_count_wdata, 32'h1236);
        issue(32'h4240FFF0, 32'h4000, 5'h0A, 32'h0);
        cmp(loop_count_wdata, 32'h1235);
        $display("test loop done");
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1 reset = 1'h0;
        t_regs;
        t_link;
        t_cond;
        t_loop;
        give_verdict;
    end
    // Watchdog: the tests need about twenty-five cycles
    initial begin
        #2000;
        fails++;
        give_verdict;
    end
endmodule // tb_branch_target_select
